/* File: logic/crd_core.sv */
// CPU datapath: registers, pairs, stack, PC, flags, memory and I/O strobes.
// Assumes memory answers in the cycle its read strobe is high.
`timescale 1ns/10ps
`include "crd_params.svh"
module crd_core (
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic CLK_EN,
  input wire logic OP_VALID,
  output logic OP_READY,
  input wire crd_pkg::crd_op_t OP_CODE,
  input wire crd_pkg::crd_alu_t ALU_FN,
  input wire logic [2:0] DEST_REG_FIELD,
  input wire logic [2:0] SRC_REG_FIELD,
  input wire logic [1:0] PAIR_FIELD,
  input wire logic [2:0] RST_FIELD,
  input wire logic [7:0] IMM_LO,
  input wire logic [7:0] IMM_HI,
  output logic [15:0] MEM_ADDR,
  output logic MEM_RD,
  output logic MEM_WR,
  output logic [7:0] MEM_WDATA,
  output logic MEM_WPAR,
  output logic MEM_BOOT_SEL,
  input wire logic [7:0] MEM_RDATA,
  input wire logic MEM_RPAR,
  input wire logic PARITY_FITTED,
  input wire logic PARITY_INT_EN,
  input wire logic KEY_BOOT_REQ,
  input wire logic TRAP_REQ,
  output logic BOOT_MODE,
  output logic PARITY_ERR,
  output logic [7:0] IO_ADDR,
  output logic IO_RD,
  output logic IO_WR,
  output logic [7:0] IO_DOUT,
  input wire logic [7:0] IO_DIN,
  output logic [7:0] INSTR_BYTE,
  output logic INSTR_VALID,
  output logic [7:0] ACC,
  output logic [4:0] FLAGS,
  output logic [15:0] PC,
  output logic [15:0] SP
);
  crd_pkg::crd_st_t st_q, st_d;
  crd_pkg::crd_op_t op_q, lat_op;
  crd_pkg::crd_alu_t fn_q, alu_fn;
  logic [2:0] dst_q, lat_dst, rf_idx;
  logic [1:0] pr_q, pw_sel;
  logic [7:0][7:0] rf_q;
  logic [15:0] pc_q, pc_d, sp_q, sp_d, tgt_q, tgt_d;
  logic [15:0] hl, in_pair, pr_val, imm16, b_addr, pw_wd;
  logic [16:0] dad;
  logic [4:0] fl_q, fl_we, fl_nx;
  logic [7:0] alu_a, alu_b, alu_res, rf_wd, b_wd;
  logic alu_cy, alu_ac, alu_z, alu_s, alu_p;
  logic boot_q, int_q, ram_q, go, lat, rf_we, pw_we, rd_go, wr_go;
  logic boot_set, boot_clr, io_rd, io_wr, ins_go, int_take, perr;

  function automatic logic [15:0] pair_of(input logic [1:0] p,
                                          input logic [7:0][7:0] rf,
                                          input logic [15:0] sp);
    if (p == `CRD_P_SP)
      pair_of = sp;
    else
      pair_of = {rf[{p, 1'b0}], rf[{p, 1'b1}]};
  endfunction : pair_of

  function automatic logic is_boot(input logic [15:0] addr, input logic bm);
    is_boot = bm && (addr < `CRD_BOOT_LIMIT);
  endfunction : is_boot

  assign hl = {rf_q[`CRD_F_H], rf_q[`CRD_F_L]};
  assign in_pair = pair_of(PAIR_FIELD, rf_q, sp_q);
  assign pr_val = pair_of(pr_q, rf_q, sp_q);
  assign imm16 = {IMM_HI, IMM_LO};
  assign dad = {1'b0, hl} + {1'b0, in_pair};
  assign OP_READY = (st_q == crd_pkg::ST_IDLE) && !int_q;
  assign go = CLK_EN && OP_VALID && OP_READY;
  assign lat_op = int_q ? crd_pkg::OP_CALL : OP_CODE;
  assign perr = ((st_q == crd_pkg::ST_RD1) || (st_q == crd_pkg::ST_RD2)) &&
                ram_q && PARITY_FITTED && !(^{MEM_RDATA, MEM_RPAR});

  crd_alu u_alu (
    .a(alu_a),
    .b(alu_b),
    .fn(alu_fn),
    .cin(fl_q[`CRD_FB_CY]),
    .acin(fl_q[`CRD_FB_AC]),
    .res(alu_res),
    .cy_o(alu_cy),
    .ac_o(alu_ac),
    .z_o(alu_z),
    .s_o(alu_s),
    .p_o(alu_p)
  );

  always_comb
  begin
    alu_a = rf_q[`CRD_F_A];
    alu_b = MEM_RDATA;
    alu_fn = fn_q;
    fl_we = 5'h00;
    fl_nx = {alu_s, alu_z, alu_p, alu_ac, alu_cy};
    rf_we = 1'b0;
    rf_idx = dst_q;
    rf_wd = MEM_RDATA;
    pw_we = 1'b0;
    pw_sel = pr_q;
    pw_wd = {MEM_RDATA, tgt_q[7:0]};
    pc_d = pc_q;
    sp_d = sp_q;
    tgt_d = tgt_q;
    rd_go = 1'b0;
    wr_go = 1'b0;
    b_addr = hl;
    b_wd = rf_q[`CRD_F_A];
    st_d = st_q;
    lat = 1'b0;
    lat_dst = DEST_REG_FIELD;
    boot_set = 1'b0;
    boot_clr = 1'b0;
    io_rd = 1'b0;
    io_wr = 1'b0;
    ins_go = 1'b0;
    int_take = 1'b0;
    case (st_q)
      crd_pkg::ST_IDLE:
      begin
        if (int_q)
        begin
          int_take = 1'b1;
          lat = 1'b1;
          tgt_d = `CRD_PAR_VEC;
        end
        else if (go)
        begin
          lat = 1'b1;
          case (OP_CODE)
            crd_pkg::OP_FETCH:
            begin
              rd_go = 1'b1;
              b_addr = pc_q;
              pc_d = pc_q + 16'h0001;
            end
            crd_pkg::OP_ALU_R, crd_pkg::OP_ALU_I:
            begin
              alu_fn = ALU_FN;
              alu_b = (OP_CODE == crd_pkg::OP_ALU_I) ? IMM_LO : rf_q[SRC_REG_FIELD];
              if ((OP_CODE == crd_pkg::OP_ALU_R) && (SRC_REG_FIELD == `CRD_F_M))
                rd_go = 1'b1;
              else
              begin
                rf_we = (ALU_FN != crd_pkg::ALU_CMP);
                rf_idx = `CRD_F_A;
                rf_wd = alu_res;
                fl_we = `CRD_FL_ALL;
              end
            end
            crd_pkg::OP_INR, crd_pkg::OP_DCR:
            begin
              alu_a = rf_q[DEST_REG_FIELD];
              alu_fn = (OP_CODE == crd_pkg::OP_INR) ? crd_pkg::ALU_INC : crd_pkg::ALU_DEC;
              rf_we = (DEST_REG_FIELD != `CRD_F_M);
              rf_idx = DEST_REG_FIELD;
              rf_wd = alu_res;
              fl_we = `CRD_FL_NOCY;
            end
            crd_pkg::OP_MOV, crd_pkg::OP_MVI:
            begin
              b_wd = (OP_CODE == crd_pkg::OP_MVI) ? IMM_LO : rf_q[SRC_REG_FIELD];
              if ((OP_CODE == crd_pkg::OP_MOV) && (SRC_REG_FIELD == `CRD_F_M))
                rd_go = 1'b1;
              else if (DEST_REG_FIELD == `CRD_F_M)
                wr_go = 1'b1;
              else
              begin
                rf_we = 1'b1;
                rf_idx = DEST_REG_FIELD;
                rf_wd = b_wd;
              end
            end
            crd_pkg::OP_LXI, crd_pkg::OP_DAD:
            begin
              pw_we = 1'b1;
              pw_sel = (OP_CODE == crd_pkg::OP_DAD) ? `CRD_P_HL : PAIR_FIELD;
              pw_wd = (OP_CODE == crd_pkg::OP_DAD) ? dad[15:0] : imm16;
              fl_nx[`CRD_FB_CY] = dad[16];
              fl_we = (OP_CODE == crd_pkg::OP_DAD) ? `CRD_FL_CY : 5'h00;
            end
            crd_pkg::OP_LDA, crd_pkg::OP_STA, crd_pkg::OP_LDAX, crd_pkg::OP_STAX:
            begin
              lat_dst = `CRD_F_A;
              b_addr = ((OP_CODE == crd_pkg::OP_LDA) || (OP_CODE == crd_pkg::OP_STA)) ?
                       imm16 : in_pair;
              rd_go = (OP_CODE == crd_pkg::OP_LDA) || (OP_CODE == crd_pkg::OP_LDAX);
              wr_go = !rd_go;
            end
            crd_pkg::OP_PUSH, crd_pkg::OP_CALL, crd_pkg::OP_RST:
              tgt_d = (OP_CODE == crd_pkg::OP_RST) ?
                      ({13'h0000, RST_FIELD} << `CRD_RST_SHIFT) : imm16;
            crd_pkg::OP_POP, crd_pkg::OP_RET:
            begin
              rd_go = 1'b1;
              b_addr = sp_q;
              sp_d = sp_q + 16'h0001;
            end
            crd_pkg::OP_JMP:
              pc_d = imm16;
            crd_pkg::OP_JPR:
              pc_d = in_pair;
            crd_pkg::OP_ROT, crd_pkg::OP_DAA:
            begin
              alu_fn = (OP_CODE == crd_pkg::OP_DAA) ? crd_pkg::ALU_DAA : ALU_FN;
              rf_we = 1'b1;
              rf_idx = `CRD_F_A;
              rf_wd = alu_res;
              fl_we = (OP_CODE == crd_pkg::OP_DAA) ? `CRD_FL_ALL : `CRD_FL_CY;
            end
            crd_pkg::OP_IN:
            begin
              io_rd = 1'b1;
              lat_dst = `CRD_F_A;
            end
            crd_pkg::OP_OUT:
              io_wr = 1'b1;
            crd_pkg::OP_SBT:
              boot_set = 1'b1;
            crd_pkg::OP_EBT:
              boot_clr = 1'b1;
            default:
            begin
            end
          endcase
        end
        if ((int_take || go) && ((lat_op == crd_pkg::OP_PUSH) ||
            (lat_op == crd_pkg::OP_CALL) || (lat_op == crd_pkg::OP_RST)))
        begin
          wr_go = 1'b1;
          b_addr = sp_q - 16'h0001;
          sp_d = sp_q - 16'h0001;
          b_wd = (lat_op == crd_pkg::OP_PUSH) ? in_pair[15:8] : pc_q[15:8];
          st_d = crd_pkg::ST_WR2;
        end
        else if (rd_go || io_rd)
          st_d = crd_pkg::ST_RD1;
      end
      crd_pkg::ST_RD1:
      begin
        st_d = crd_pkg::ST_IDLE;
        case (op_q)
          crd_pkg::OP_FETCH:
            ins_go = 1'b1;
          crd_pkg::OP_ALU_R:
          begin
            rf_we = (fn_q != crd_pkg::ALU_CMP);
            rf_idx = `CRD_F_A;
            rf_wd = alu_res;
            fl_we = `CRD_FL_ALL;
          end
          crd_pkg::OP_MOV, crd_pkg::OP_LDA, crd_pkg::OP_LDAX:
            rf_we = 1'b1;
          crd_pkg::OP_IN:
          begin
            rf_we = 1'b1;
            rf_wd = IO_DIN;
          end
          crd_pkg::OP_POP, crd_pkg::OP_RET:
          begin
            tgt_d = {tgt_q[15:8], MEM_RDATA};
            rd_go = 1'b1;
            b_addr = sp_q;
            sp_d = sp_q + 16'h0001;
            st_d = crd_pkg::ST_RD2;
          end
          default:
          begin
          end
        endcase
      end
      crd_pkg::ST_RD2:
      begin
        st_d = crd_pkg::ST_IDLE;
        if (op_q == crd_pkg::OP_RET)
          pc_d = pw_wd;
        else
          pw_we = 1'b1;
      end
      crd_pkg::ST_WR2:
      begin
        st_d = crd_pkg::ST_IDLE;
        wr_go = 1'b1;
        b_addr = sp_q - 16'h0001;
        sp_d = sp_q - 16'h0001;
        b_wd = (op_q == crd_pkg::OP_PUSH) ? pr_val[7:0] : pc_q[7:0];
        if (op_q != crd_pkg::OP_PUSH)
          pc_d = tgt_q;
      end
      default:
        st_d = crd_pkg::ST_IDLE;
    endcase
  end

  // Sequencer and latched operation fields
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      st_q <= crd_pkg::ST_IDLE;
      op_q <= crd_pkg::OP_NOP;
      fn_q <= crd_pkg::ALU_ADD;
      dst_q <= `CRD_F_A;
      pr_q <= `CRD_P_HL;
      tgt_q <= `CRD_PC_RST;
      ram_q <= 1'b0;
    end
    else if (CLK_EN)
    begin
      st_q <= st_d;
      tgt_q <= tgt_d;
      ram_q <= rd_go && !is_boot(b_addr, boot_q);
      if (lat)
      begin
        op_q <= lat_op;
        fn_q <= ALU_FN;
        dst_q <= lat_dst;
        pr_q <= PAIR_FIELD;
      end
    end
  end

  // General registers and pairs
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      rf_q <= `CRD_REG_RST;
    else if (CLK_EN)
    begin
      if (rf_we)
        rf_q[rf_idx] <= rf_wd;
      if (pw_we && (pw_sel != `CRD_P_SP))
      begin
        rf_q[{pw_sel, 1'b0}] <= pw_wd[15:8];
        rf_q[{pw_sel, 1'b1}] <= pw_wd[7:0];
      end
    end
  end

  // Program counter and stack pointer
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      pc_q <= `CRD_PC_RST;
      sp_q <= `CRD_SP_RST;
    end
    else if (CLK_EN)
    begin
      pc_q <= pc_d;
      sp_q <= (pw_we && (pw_sel == `CRD_P_SP)) ? pw_wd : sp_d;
    end
  end

  // Condition flags
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      fl_q <= `CRD_FLG_RST;
    else if (CLK_EN)
      fl_q <= (fl_q & ~fl_we) | (fl_nx & fl_we);
  end

  // Bootstrap mode and parity interrupt request
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      boot_q <= `CRD_BOOT_RST;
      int_q <= 1'b0;
    end
    else if (CLK_EN)
    begin
      if (boot_set || KEY_BOOT_REQ || TRAP_REQ || int_take)
        boot_q <= 1'b1;
      else if (boot_clr)
        boot_q <= 1'b0;
      if (perr && PARITY_INT_EN)
        int_q <= 1'b1;
      else if (int_take)
        int_q <= 1'b0;
    end
  end

  // Memory and I/O strobes
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      MEM_ADDR <= `CRD_PC_RST;
      MEM_RD <= 1'b0;
      MEM_WR <= 1'b0;
      MEM_WDATA <= 8'h00;
      MEM_WPAR <= 1'b1;
      MEM_BOOT_SEL <= 1'b0;
      IO_ADDR <= 8'h00;
      IO_RD <= 1'b0;
      IO_WR <= 1'b0;
      IO_DOUT <= 8'h00;
      INSTR_BYTE <= 8'h00;
      INSTR_VALID <= 1'b0;
      PARITY_ERR <= 1'b0;
    end
    else if (CLK_EN)
    begin
      MEM_RD <= rd_go;
      MEM_WR <= wr_go;
      IO_RD <= io_rd;
      IO_WR <= io_wr;
      INSTR_VALID <= ins_go;
      PARITY_ERR <= perr;
      if (rd_go || wr_go)
      begin
        MEM_ADDR <= b_addr;
        MEM_BOOT_SEL <= is_boot(b_addr, boot_q);
      end
      if (wr_go)
      begin
        MEM_WDATA <= b_wd;
        MEM_WPAR <= ~^b_wd;
      end
      if (io_rd || io_wr)
        IO_ADDR <= IMM_LO;
      if (io_wr)
        IO_DOUT <= rf_q[`CRD_F_A];
      if (ins_go)
        INSTR_BYTE <= MEM_RDATA;
    end
  end

  assign ACC = rf_q[`CRD_F_A];
  assign FLAGS = fl_q;
  assign PC = pc_q;
  assign SP = sp_q;
  assign BOOT_MODE = boot_q;
endmodule : crd_core

/* File: logic/crd_params.svh */
// Constants for the CPU register and ALU datapath.
// Assumes inclusion by bare name from the design files.
// Operation
// - Eight-bit parallel add, subtract and logic
// - Accumulator with register or M operand
// - Pair addition adds any pair into H/L
// - Bootstrap region overlays RAM from zero
// - Bootstrap entered four ways, left by exit
// - Odd parity ninth bit stored and checked
// - Parity error interrupts to bootstrap vector
// - Accumulator takes results and I/O bytes
// - Registers increment, decrement, load from any
// - M address is H high, L low
// - Pairs B/C, D/E, H/L address or add
// - Stack pointer holds last pushed byte address
// - Sequential fetch, low byte at lowest address
// - Direct address: byte 2 low, byte 3 high
// - Indirect: first pair register is high byte
// - Restart calls eight times its field
// - Zero and sign flags from result
// - Parity flag set on even ones
// - Carry on carry out or borrow
// - Auxiliary carry from bit 3, feeds adjust
// - Register fields: 111 A, 000-101 B..L
// - Pair fields: 00 BC, 01 DE, 10 HL, 11 SP
`ifndef CRD_PARAMS_SVH
`define CRD_PARAMS_SVH
`define CRD_W 8
`define CRD_F_B 3'h0
`define CRD_F_C 3'h1
`define CRD_F_D 3'h2
`define CRD_F_E 3'h3
`define CRD_F_H 3'h4
`define CRD_F_L 3'h5
`define CRD_F_M 3'h6
`define CRD_F_A 3'h7
`define CRD_P_HL 2'h2
`define CRD_P_SP 2'h3
`define CRD_BOOT_LIMIT 16'h1000
`define CRD_PAR_VEC 16'h0024
`define CRD_RST_SHIFT 3
`define CRD_PC_RST 16'h0000
`define CRD_SP_RST 16'h0000
`define CRD_REG_RST 64'h0
`define CRD_FLG_RST 5'h00
`define CRD_BOOT_RST 1'b1
`define CRD_FB_CY 0
`define CRD_FB_AC 1
`define CRD_FL_ALL 5'h1F
`define CRD_FL_NOCY 5'h1E
`define CRD_FL_CY 5'h01
`define CRD_NIB_MAX 4'h9
`define CRD_DAA_LO 8'h06
`define CRD_DAA_HI 8'h60
`endif

/* File: logic/crd_pkg.sv */
// Types shared by the datapath core and its ALU.
// Assumes nothing of its surroundings.
package crd_pkg;
  typedef enum logic [4:0] {
    OP_NOP, OP_FETCH, OP_ALU_R, OP_ALU_I, OP_INR, OP_DCR, OP_MOV, OP_MVI,
    OP_LXI, OP_DAD, OP_LDA, OP_STA, OP_LDAX, OP_STAX, OP_PUSH, OP_POP,
    OP_JMP, OP_JPR, OP_CALL, OP_RST, OP_RET, OP_ROT, OP_DAA, OP_IN,
    OP_OUT, OP_SBT, OP_EBT
  } crd_op_t;
  typedef enum logic [3:0] {
    ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBB, ALU_AND, ALU_XOR, ALU_OR, ALU_CMP,
    ALU_INC, ALU_DEC, ALU_RLC, ALU_RRC, ALU_DAA
  } crd_alu_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_RD1 = 2'h1,
    ST_RD2 = 2'h3,
    ST_WR2 = 2'h2
  } crd_st_t;
endpackage : crd_pkg

/* File: logic/crd_alu.sv */
// Eight-bit combinational ALU with flag outputs.
// Assumes the core registers results and flags.
`timescale 1ns/10ps
`include "crd_params.svh"
module crd_alu (
  input wire logic [`CRD_W-1:0] a,
  input wire logic [`CRD_W-1:0] b,
  input wire crd_pkg::crd_alu_t fn,
  input wire logic cin,
  input wire logic acin,
  output logic [`CRD_W-1:0] res,
  output logic cy_o,
  output logic ac_o,
  output logic z_o,
  output logic s_o,
  output logic p_o
);
  logic sub, c0, lo_adj, hi_adj;
  logic [7:0] bx, lo_val;
  logic [8:0] sum, t9;
  logic [4:0] nib, nib2;

  always_comb
  begin
    sub = (fn == crd_pkg::ALU_SUB) || (fn == crd_pkg::ALU_SBB) ||
          (fn == crd_pkg::ALU_CMP) || (fn == crd_pkg::ALU_DEC);
    bx = b;
    if ((fn == crd_pkg::ALU_INC) || (fn == crd_pkg::ALU_DEC))
      bx = 8'h01;
    if (sub)
      bx = ~bx;
    c0 = sub;
    if (fn == crd_pkg::ALU_ADC)
      c0 = cin;
    if (fn == crd_pkg::ALU_SBB)
      c0 = ~cin;
    sum = {1'b0, a} + {1'b0, bx} + {8'h00, c0};
    nib = {1'b0, a[3:0]} + {1'b0, bx[3:0]} + {4'h0, c0};
    res = sum[7:0];
    cy_o = sum[8] ^ sub;
    ac_o = nib[4];
    lo_adj = (a[3:0] > `CRD_NIB_MAX) || acin;
    lo_val = lo_adj ? `CRD_DAA_LO : 8'h00;
    t9 = {1'b0, a} + {1'b0, lo_val};
    nib2 = {1'b0, a[3:0]} + {1'b0, lo_val[3:0]};
    hi_adj = (t9[7:4] > `CRD_NIB_MAX) || cin || t9[8];
    case (fn)
      crd_pkg::ALU_AND:
      begin
        res = a & b;
        cy_o = 1'b0;
        ac_o = 1'b0;
      end
      crd_pkg::ALU_XOR:
      begin
        res = a ^ b;
        cy_o = 1'b0;
        ac_o = 1'b0;
      end
      crd_pkg::ALU_OR:
      begin
        res = a | b;
        cy_o = 1'b0;
        ac_o = 1'b0;
      end
      crd_pkg::ALU_RLC:
      begin
        res = {a[6:0], a[7]};
        cy_o = a[7];
        ac_o = acin;
      end
      crd_pkg::ALU_RRC:
      begin
        res = {a[0], a[7:1]};
        cy_o = a[0];
        ac_o = acin;
      end
      crd_pkg::ALU_DAA:
      begin
        res = t9[7:0] + (hi_adj ? `CRD_DAA_HI : 8'h00);
        cy_o = hi_adj;
        ac_o = nib2[4];
      end
      default:
      begin
      end
    endcase
  end

  assign z_o = (res == 8'h00);
  assign s_o = res[7];
  assign p_o = ~^res;
endmodule : crd_alu

/* File: testbench/crd_core_assertions.sv */
// Checker for the datapath core, bound to its ports.
// Assumes a core clocked by REF_CLK with synchronous active-high SYS_RST.
`timescale 1ns/10ps
module crd_core_chk (
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic CLK_EN,
  input wire logic OP_VALID,
  input wire logic OP_READY,
  input wire crd_pkg::crd_op_t OP_CODE,
  input wire crd_pkg::crd_alu_t ALU_FN,
  input wire logic [2:0] RST_FIELD,
  input wire logic [7:0] IMM_LO,
  input wire logic [7:0] IMM_HI,
  input wire logic [15:0] MEM_ADDR,
  input wire logic MEM_RD,
  input wire logic MEM_WR,
  input wire logic [7:0] MEM_WDATA,
  input wire logic MEM_WPAR,
  input wire logic MEM_BOOT_SEL,
  input wire logic [7:0] MEM_RDATA,
  input wire logic MEM_RPAR,
  input wire logic PARITY_FITTED,
  input wire logic PARITY_INT_EN,
  input wire logic KEY_BOOT_REQ,
  input wire logic BOOT_MODE,
  input wire logic PARITY_ERR,
  input wire logic [7:0] IO_ADDR,
  input wire logic IO_WR,
  input wire logic [7:0] IO_DOUT,
  input wire logic [7:0] ACC,
  input wire logic [4:0] FLAGS,
  input wire logic [15:0] PC,
  input wire logic [15:0] SP
);
  wire tk = OP_VALID && OP_READY && CLK_EN;
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (SYS_RST);
  a_wpar_odd: assert property (MEM_WR |-> ^{MEM_WPAR, MEM_WDATA})
    else $error("write parity not odd");
  a_par_check: assert property (MEM_RD && CLK_EN && PARITY_FITTED && !MEM_BOOT_SEL
    && !(^{MEM_RPAR, MEM_RDATA}) |=> PARITY_ERR)
    else $error("parity mismatch not flagged");
  a_par_vector: assert property (PARITY_ERR && PARITY_INT_EN
    |-> ##[1:8] (PC == 16'h0024 && BOOT_MODE))
    else $error("parity interrupt did not vector");
  a_key_boot: assert property (KEY_BOOT_REQ && CLK_EN |=> BOOT_MODE)
    else $error("keyboard request left boot mode off");
  a_fetch_step: assert property (tk && OP_CODE == crd_pkg::OP_FETCH
    |=> MEM_RD && MEM_ADDR == $past(PC) && PC == $past(PC) + 16'h1)
    else $error("fetch address or step wrong");
  a_direct_addr: assert property (tk && OP_CODE == crd_pkg::OP_LDA
    |=> MEM_RD && MEM_ADDR == {$past(IMM_HI), $past(IMM_LO)})
    else $error("direct address wrong");
  a_push_order: assert property (tk && OP_CODE == crd_pkg::OP_PUSH
    |=> MEM_WR && MEM_ADDR == $past(SP) - 16'h1
    ##1 MEM_WR && MEM_ADDR == $past(SP, 2) - 16'h2 && SP == MEM_ADDR)
    else $error("push order wrong");
  a_restart_tgt: assert property (tk && OP_CODE == crd_pkg::OP_RST
    |=> ##1 PC == {10'h0, $past(RST_FIELD, 2), 3'h0} && SP == $past(SP, 2) - 16'h2)
    else $error("restart target wrong");
  a_out_acc: assert property (tk && OP_CODE == crd_pkg::OP_OUT
    |=> IO_WR && IO_DOUT == $past(ACC) && IO_ADDR == $past(IMM_LO))
    else $error("output byte not from accumulator");
  a_flag_zsp: assert property (tk && OP_CODE == crd_pkg::OP_ALU_I
    && ALU_FN != crd_pkg::ALU_CMP
    |=> FLAGS[4] == ACC[7] && FLAGS[3] == (ACC == 8'h00) && FLAGS[2] == ~^ACC)
    else $error("sign zero parity flags wrong");
endmodule : crd_core_chk

bind crd_core crd_core_chk chk_u (.*);

/* File: testbench/crd_mem_model.sv */
// Main memory with ninth parity bit, bootstrap image and one I/O port.
// Assumes strobes last one cycle and reads are answered in the same cycle.
`timescale 1ns/10ps
module crd_mem_model (
  input wire logic REF_CLK,
  input wire logic [15:0] MEM_ADDR,
  input wire logic MEM_RD,
  input wire logic MEM_WR,
  input wire logic [7:0] MEM_WDATA,
  input wire logic MEM_WPAR,
  input wire logic MEM_BOOT_SEL,
  input wire logic BAD_PAR,
  output logic [7:0] MEM_RDATA,
  output logic MEM_RPAR,
  input wire logic IO_RD,
  input wire logic IO_WR,
  input wire logic [7:0] IO_DOUT,
  output logic [7:0] IO_DIN
);
  logic [8:0] ram [0:65535];
  logic [8:0] rd;
  logic [8:0] last_q = 9'h000;
  logic [7:0] io_q = 8'h00;
  always_comb
  begin
    // Boot image is an arbitrary function of the address
    rd = MEM_BOOT_SEL ? {1'b0, MEM_ADDR[7:0] ^ 8'hC3} : ram[MEM_ADDR];
    {MEM_RPAR, MEM_RDATA} = MEM_RD ? {rd[8] ^ BAD_PAR, rd[7:0]} : ~last_q;
    IO_DIN = IO_RD ? io_q : ~io_q;
  end
  always @(posedge REF_CLK)
  begin
    if (MEM_WR && !MEM_BOOT_SEL)
      ram[MEM_ADDR] <= {MEM_WPAR, MEM_WDATA};
    if (MEM_RD)
      last_q <= {MEM_RPAR, MEM_RDATA};
    if (IO_WR)
      io_q <= IO_DOUT;
  end
endmodule : crd_mem_model

/* File: testbench/crd_core_test.sv */
// Self-checking bench for the datapath core and its memory partner.
// Assumes the checker is bound in by its own file.
`timescale 1ns/10ps
module crd_core_test;
  logic REF_CLK = 1'b0, SYS_RST = 1'b1, CLK_EN = 1'b1, OP_VALID = 1'b0, OP_READY;
  crd_pkg::crd_op_t OP_CODE = crd_pkg::OP_NOP;
  crd_pkg::crd_alu_t ALU_FN = crd_pkg::ALU_ADD;
  logic [2:0] DEST_REG_FIELD = 3'h0, SRC_REG_FIELD = 3'h0, RST_FIELD = 3'h0;
  logic [1:0] PAIR_FIELD = 2'h0;
  logic [7:0] IMM_LO = 8'h00, IMM_HI = 8'h00, MEM_WDATA, MEM_RDATA, IO_ADDR, IO_DOUT;
  logic [15:0] MEM_ADDR, PC, SP;
  logic MEM_RD, MEM_WR, MEM_WPAR, MEM_BOOT_SEL, MEM_RPAR, BOOT_MODE, PARITY_ERR;
  logic PARITY_FITTED = 1'b1, PARITY_INT_EN = 1'b0, KEY_BOOT_REQ = 1'b0;
  logic TRAP_REQ = 1'b0, BAD_PAR = 1'b0, IO_RD, IO_WR, INSTR_VALID;
  logic [7:0] IO_DIN, INSTR_BYTE, ACC;
  logic [4:0] FLAGS;
  int failures = 0;
  int checks_done = 0;
  int perr_n = 0;
  int ivld_n = 0;
  crd_core dut_u (.*);
  crd_mem_model mem_u (.*);
  initial
  begin
    forever #50 REF_CLK = ~REF_CLK;
  end
  // One-cycle pulses counted where they stand
  always @(posedge REF_CLK)
  begin
    if (PARITY_ERR === 1'b1)
      perr_n++;
    if (INSTR_VALID === 1'b1)
      ivld_n++;
  end
  task automatic complete_run();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    checks_done++;
    if (g !== e)
    begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wrdy();
    int n;
    n = 0;
    while (OP_READY !== 1'b1 && n < 50)
    begin
      @(posedge REF_CLK);
      #1;
      n++;
    end
    if (n >= 50)
    begin
      failures++;
      $display("[ERR] %0t ready never returned", $time);
    end
  endtask : wrdy
  // Entered and left just after a rising edge
  task automatic op(input crd_pkg::crd_op_t c, input crd_pkg::crd_alu_t f,
    input logic [2:0] d, input logic [2:0] s, input logic [1:0] p, input logic [15:0] im);
    OP_CODE = c;
    ALU_FN = f;
    DEST_REG_FIELD = d;
    SRC_REG_FIELD = s;
    PAIR_FIELD = p;
    RST_FIELD = im[2:0];
    {IMM_HI, IMM_LO} = im;
    OP_VALID = 1'b1;
    wrdy();
    @(posedge REF_CLK);
    #1;
    OP_VALID = 1'b0;
    wrdy();
    @(posedge REF_CLK);
    #1;
  endtask : op
  task automatic mvi(input logic [2:0] d, input logic [7:0] v);
    op(crd_pkg::OP_MVI, crd_pkg::ALU_ADD, d, 3'h0, 2'h0, {8'h00, v});
  endtask : mvi
  task automatic alui(input crd_pkg::crd_alu_t f, input logic [7:0] v);
    op(crd_pkg::OP_ALU_I, f, 3'h7, 3'h0, 2'h0, {8'h00, v});
  endtask : alui
  task automatic mop(input crd_pkg::crd_op_t c, input logic [1:0] p, input logic [15:0] im);
    op(c, crd_pkg::ALU_ADD, 3'h7, 3'h0, p, im);
  endtask : mop
  initial
  begin
    // About thirty times the expected test length
    #300000;
    failures++;
    $display("[ERR] %0t watchdog expired", $time);
    complete_run();
  end
  initial
  begin
    repeat (6) @(posedge REF_CLK);
    #1;
    SYS_RST = 1'b0;
    chk(PC, 16'h0000);
    chk({BOOT_MODE, FLAGS, ACC}, {1'b1, 5'h00, 8'h00});
    $display("test reset done");
    mvi(3'h7, 8'h7F);
    alui(crd_pkg::ALU_ADD, 8'h01);
    chk({FLAGS, ACC}, {5'h12, 8'h80});
    alui(crd_pkg::ALU_SUB, 8'h81);
    chk({FLAGS, ACC}, {5'h15, 8'hFF});
    alui(crd_pkg::ALU_XOR, 8'hFF);
    chk({FLAGS, ACC}, {5'h0C, 8'h00});
    op(crd_pkg::OP_INR, crd_pkg::ALU_INC, 3'h7, 3'h0, 2'h0, 16'h0000);
    chk(ACC, 8'h01);
    mvi(3'h7, 8'h99);
    alui(crd_pkg::ALU_ADD, 8'h01);
    op(crd_pkg::OP_DAA, crd_pkg::ALU_DAA, 3'h7, 3'h0, 2'h0, 16'h0000);
    chk({FLAGS, ACC}, {5'h0F, 8'h00});
    $display("test alu done");
    mvi(3'h7, 8'h5A);
    mop(crd_pkg::OP_STA, 2'h0, 16'h1234);
    chk(mem_u.ram[16'h1234], 9'h15A);
    mvi(3'h4, 8'h12);
    mvi(3'h5, 8'h34);
    mvi(3'h7, 8'h01);
    op(crd_pkg::OP_ALU_R, crd_pkg::ALU_ADD, 3'h7, 3'h6, 2'h0, 16'h0000);
    chk(ACC, 8'h5B);
    mvi(3'h0, 8'hAB);
    op(crd_pkg::OP_MOV, crd_pkg::ALU_ADD, 3'h7, 3'h0, 2'h0, 16'h0000);
    chk(ACC, 8'hAB);
    $display("test memory done");
    mop(crd_pkg::OP_LXI, 2'h3, 16'h2000);
    chk(SP, 16'h2000);
    mvi(3'h1, 8'hCD);
    mop(crd_pkg::OP_PUSH, 2'h0, 16'h0000);
    chk({mem_u.ram[16'h1FFF][7:0], mem_u.ram[16'h1FFE][7:0]}, 16'hABCD);
    chk(SP, 16'h1FFE);
    mop(crd_pkg::OP_POP, 2'h3, 16'h0000);
    chk(SP, 16'hABCD);
    mop(crd_pkg::OP_DAD, 2'h0, 16'h0000);
    mvi(3'h7, 8'h3C);
    mop(crd_pkg::OP_STAX, 2'h2, 16'h0000);
    chk(mem_u.ram[16'hBE01][7:0], 8'h3C);
    $display("test stack done");
    mop(crd_pkg::OP_OUT, 2'h0, 16'h0042);
    mvi(3'h7, 8'h00);
    mop(crd_pkg::OP_IN, 2'h0, 16'h0042);
    chk(ACC, 8'h3C);
    mop(crd_pkg::OP_RST, 2'h0, 16'h0005);
    chk(PC, 16'h0028);
    mop(crd_pkg::OP_FETCH, 2'h0, 16'h0000);
    chk({PC, INSTR_BYTE}, {16'h0029, 8'hEB});
    chk(ivld_n, 1);
    mop(crd_pkg::OP_CALL, 2'h0, 16'h3000);
    chk(PC, 16'h3000);
    mop(crd_pkg::OP_RET, 2'h0, 16'h0000);
    chk(PC, 16'h0029);
    chk(SP, 16'hABCB);
    $display("test branch done");
    mop(crd_pkg::OP_EBT, 2'h0, 16'h0000);
    chk(BOOT_MODE, 1'b0);
    mop(crd_pkg::OP_STA, 2'h0, 16'h0028);
    mop(crd_pkg::OP_SBT, 2'h0, 16'h0000);
    mop(crd_pkg::OP_LDA, 2'h0, 16'h0028);
    chk({BOOT_MODE, ACC}, {1'b1, 8'hEB});
    mop(crd_pkg::OP_EBT, 2'h0, 16'h0000);
    mop(crd_pkg::OP_LDA, 2'h0, 16'h0028);
    chk(ACC, 8'h3C);
    KEY_BOOT_REQ = 1'b1;
    @(posedge REF_CLK);
    #1;
    KEY_BOOT_REQ = 1'b0;
    chk(BOOT_MODE, 1'b1);
    mop(crd_pkg::OP_EBT, 2'h0, 16'h0000);
    TRAP_REQ = 1'b1;
    @(posedge REF_CLK);
    #1;
    TRAP_REQ = 1'b0;
    chk(BOOT_MODE, 1'b1);
    mop(crd_pkg::OP_EBT, 2'h0, 16'h0000);
    // Frozen core takes no request
    CLK_EN = 1'b0;
    mvi(3'h7, 8'h55);
    chk(ACC, 8'h3C);
    CLK_EN = 1'b1;
    $display("test boot done");
    chk(perr_n, 0);
    BAD_PAR = 1'b1;
    PARITY_FITTED = 1'b0;
    mop(crd_pkg::OP_LDA, 2'h0, 16'h1234);
    chk(perr_n, 0);
    PARITY_FITTED = 1'b1;
    mop(crd_pkg::OP_LDA, 2'h0, 16'h1234);
    chk(perr_n, 1);
    chk(PC, 16'h0029);
    PARITY_INT_EN = 1'b1;
    mop(crd_pkg::OP_LDA, 2'h0, 16'h1234);
    BAD_PAR = 1'b0;
    chk(perr_n, 2);
    chk({BOOT_MODE, PC}, {1'b1, 16'h0024});
    $display("test parity done");
    complete_run();
  end
endmodule : crd_core_test
